// ---- hdl/cmp_ctrl_regs.svh ----
`ifndef CMP_CTRL_REGS_SVH
`define CMP_CTRL_REGS_SVH

// Control register field positions
`define CMP_BIT_ENABLE 3'd7
`define CMP_BIT_OUT 3'd6
`define CMP_BIT_RISE 3'd5
`define CMP_BIT_FALL 3'd4
`define CMP_POS_HI 3
`define CMP_POS_LO 2
`define CMP_NEG_HI 1
`define CMP_NEG_LO 0

// Reset value of each control register
`define CMP_CTRL_RESET 8'h00

`endif

// ---- hdl/cmp_ctrl_pkg.sv ----
package cmp_ctrl_pkg;

	// Hysteresis codes
	typedef enum logic [1:0] {
		HYST_OFF = 2'b00,
		HYST_2MV = 2'b01,
		HYST_4MV = 2'b10,
		HYST_10MV = 2'b11
	} hyst_type;

	// Port pin drive mode
	typedef enum logic {
		PIN_OPEN_DRAIN = 1'b0,
		PIN_PUSH_PULL = 1'b1
	} pin_mode_type;

endpackage

// ---- hdl/dual_comparator_control.sv ----
`include "cmp_ctrl_regs.svh"

// Function
// - Each comparator has its own enable bit
// - Disabled: routed pin low, interrupts suspended
// - Output state bit readable at any time
// - Interrupt requests on rising and falling edges
// - Falling edge sets the fall flag
// - Rising edge sets the rise flag independently
// - Flags stay set until software clears them
// - Comparator 0 selectable as reset source
// - Comparator 1 has no reset path
// - Low four bits select hysteresis
// - Comparator 1 mirrors comparator 0, own register
// - Output routable to port, open-drain or push-pull
// - Bits 7 enable, 6 out, 5 rise, 4 fall
// - Bits 3-2 positive, 1-0 negative hysteresis
module dual_comparator_control (
	input wire logic clk,
	input wire logic rst,
	input wire logic [1:0] ctrl_write,
	input wire logic [7:0] ctrl_wdata,
	input wire logic [1:0] cmp_raw,
	input wire logic cmp0_reset_sel,
	input wire logic [1:0] route_en,
	input wire logic [1:0] route_push_pull,
	output logic [7:0] cmp0_control_reg,
	output logic [7:0] cmp1_control_reg,
	output logic [1:0] cmp_power_en,
	output cmp_ctrl_pkg::hyst_type cmp0_pos_hyst_sel,
	output cmp_ctrl_pkg::hyst_type cmp0_neg_hyst_sel,
	output cmp_ctrl_pkg::hyst_type cmp1_pos_hyst_sel,
	output cmp_ctrl_pkg::hyst_type cmp1_neg_hyst_sel,
	output logic [1:0] rise_irq,
	output logic [1:0] fall_irq,
	output logic cmp0_reset_req,
	output logic [1:0] pin_out,
	output logic [1:0] pin_oe
);

	// ----------------------------------------
	// Storage
	// ----------------------------------------
	logic [1:0] enable;
	logic [1:0] rise_flag;
	logic [1:0] fall_flag;
	logic [3:0] hyst [2];
	logic [1:0] sync_a;
	logic [1:0] sync_b;
	logic [1:0] out_state;
	logic [1:0] rise_evt;
	logic [1:0] fall_evt;

	// ----------------------------------------
	// Helper functions
	// ----------------------------------------
	// Edge of a synchronised level against its one-cycle-old copy, gated by enable
	function automatic logic [1:0] edge_event(input logic [1:0] now_lvl,
		input logic [1:0] old_lvl, input logic [1:0] en);
		return now_lvl & ~old_lvl & en;
	endfunction

	// Next sticky flag: the event is or-ed in last, so a clear never hides it
	function automatic logic next_flag(input logic flag_now, input logic evt,
		input logic wr, input logic wr_bit);
		return evt | (flag_now & ~(wr & ~wr_bit));
	endfunction

	// Readback word in control register order
	function automatic logic [7:0] ctrl_word(input logic en, input logic out_lvl,
		input logic rise, input logic fall, input logic [3:0] hyst_bits);
		return {en, out_lvl, rise, fall, hyst_bits};
	endfunction

	// Positive hysteresis code from the low nibble
	function automatic cmp_ctrl_pkg::hyst_type pos_code(input logic [3:0] hyst_bits);
		return cmp_ctrl_pkg::hyst_type'(hyst_bits[`CMP_POS_HI:`CMP_POS_LO]);
	endfunction

	// Negative hysteresis code from the low nibble
	function automatic cmp_ctrl_pkg::hyst_type neg_code(input logic [3:0] hyst_bits);
		return cmp_ctrl_pkg::hyst_type'(hyst_bits[`CMP_NEG_HI:`CMP_NEG_LO]);
	endfunction

	// Output enable: push-pull always drives; open drain drives only a low level
	function automatic logic pin_drive_en(input logic routed, input logic push_pull,
		input logic level);
		return routed & (push_pull | ~level);
	endfunction

	// ----------------------------------------
	// Configuration
	// ----------------------------------------
	// Writable part of a control register
	always_ff @(posedge clk) begin
		for (int i = 0; i < 2; i++) begin
			if (rst) begin
				enable[i] <= 1'b0;
				hyst[i] <= 4'h0;
			end else if (ctrl_write[i]) begin
				enable[i] <= ctrl_wdata[`CMP_BIT_ENABLE];
				hyst[i] <= ctrl_wdata[`CMP_POS_HI:`CMP_NEG_LO];
			end
		end
	end

	// ----------------------------------------
	// Input synchroniser
	// ----------------------------------------
	// Two-stage synchroniser; sync_a feeds only sync_b, never any logic
	// out_state is a third stage, the old level that edge detection compares with
	always_ff @(posedge clk) begin
		if (rst) begin
			sync_a <= 2'h0;
			sync_b <= 2'h0;
			out_state <= 2'h0;
		end else begin
			sync_a <= cmp_raw;
			sync_b <= sync_a;
			out_state <= sync_b;
		end
	end

	// ----------------------------------------
	// Edge events
	// ----------------------------------------
	// Edges count only while enabled; a powered-down core must not flag
	assign rise_evt = edge_event(sync_b, out_state, enable);
	assign fall_evt = edge_event(out_state, sync_b, enable);

	// Sticky flags: event set wins over a software clear
	// Writing 1 to a flag bit keeps it; only a 0 clears, and a write never sets
	always_ff @(posedge clk) begin
		for (int i = 0; i < 2; i++) begin
			if (rst) begin
				rise_flag[i] <= 1'b0;
				fall_flag[i] <= 1'b0;
			end else if (rise_evt[i] || fall_evt[i] || ctrl_write[i]) begin
				rise_flag[i] <= next_flag(rise_flag[i], rise_evt[i], ctrl_write[i],
					ctrl_wdata[`CMP_BIT_RISE]);
				fall_flag[i] <= next_flag(fall_flag[i], fall_evt[i], ctrl_write[i],
					ctrl_wdata[`CMP_BIT_FALL]);
			end
		end
	end

	// ----------------------------------------
	// Registered outputs
	// ----------------------------------------
	// Readback word built from the stored state
	// The output bit shows the synchronised level, so it lags the core by three clocks
	always_ff @(posedge clk) begin
		if (rst) begin
			cmp0_control_reg <= `CMP_CTRL_RESET;
			cmp1_control_reg <= `CMP_CTRL_RESET;
		end else begin
			cmp0_control_reg <= ctrl_word(enable[0], sync_b[0], rise_flag[0], fall_flag[0],
				hyst[0]);
			cmp1_control_reg <= ctrl_word(enable[1], sync_b[1], rise_flag[1], fall_flag[1],
				hyst[1]);
		end
	end

	// Analog-side controls
	always_ff @(posedge clk) begin
		if (rst) begin
			cmp_power_en <= 2'h0;
			cmp0_pos_hyst_sel <= cmp_ctrl_pkg::HYST_OFF;
			cmp0_neg_hyst_sel <= cmp_ctrl_pkg::HYST_OFF;
			cmp1_pos_hyst_sel <= cmp_ctrl_pkg::HYST_OFF;
			cmp1_neg_hyst_sel <= cmp_ctrl_pkg::HYST_OFF;
		end else begin
			cmp_power_en <= enable;
			cmp0_pos_hyst_sel <= pos_code(hyst[0]);
			cmp0_neg_hyst_sel <= neg_code(hyst[0]);
			cmp1_pos_hyst_sel <= pos_code(hyst[1]);
			cmp1_neg_hyst_sel <= neg_code(hyst[1]);
		end
	end

	// Interrupt requests: level of each sticky flag, held off while disabled
	// Flags persist while disabled, so a pending request returns on enable
	always_ff @(posedge clk) begin
		if (rst) begin
			rise_irq <= 2'h0;
			fall_irq <= 2'h0;
		end else begin
			rise_irq <= rise_flag & enable;
			fall_irq <= fall_flag & enable;
		end
	end

	// ----------------------------------------
	// Reset routing
	// ----------------------------------------
	// Reset routing exists for comparator 0 only
	// Comparator 1 deliberately has no path to the reset request
	always_ff @(posedge clk) begin
		if (rst) begin
			cmp0_reset_req <= 1'b0;
		end else begin
			cmp0_reset_req <= cmp0_reset_sel & enable[0] & sync_b[0];
		end
	end

	// ----------------------------------------
	// Pin drive
	// ----------------------------------------
	// Pin drive: open drain only pulls low, so a high releases the pin
	always_ff @(posedge clk) begin
		for (int i = 0; i < 2; i++) begin
			if (rst) begin
				pin_out[i] <= 1'b0;
				pin_oe[i] <= 1'b0;
			end else begin
				pin_out[i] <= enable[i] & sync_b[i];
				pin_oe[i] <= pin_drive_en(route_en[i],
					route_push_pull[i] == cmp_ctrl_pkg::PIN_PUSH_PULL, enable[i] & sync_b[i]);
			end
		end
	end

endmodule // dual_comparator_control

// ---- sim/cmp_model.sv ----
module cmp_model (
	input wire logic clk,
	input wire logic [1:0] pwr,
	input wire logic [1:0] lvl,
	output logic [1:0] raw = 2'h1
);
	timeunit 1ns;
	timeprecision 1ns;
	// Unpowered cores give no usable level, so the output flips each cycle
	always @(posedge clk) begin
		raw <= (pwr & lvl) | (~pwr & ~raw);
	end
endmodule // cmp_model

// ---- sim/dual_comparator_control_chk.sv ----
module dual_comparator_control_chk (
	input wire logic clk,
	input wire logic rst,
	input wire logic [1:0] ctrl_write,
	input wire logic [7:0] ctrl_wdata,
	input wire logic [1:0] cmp_raw,
	input wire logic [7:0] cmp0_control_reg,
	input wire logic [7:0] cmp1_control_reg,
	input wire logic [1:0] cmp_power_en,
	input wire logic [1:0] cmp0_pos_hyst_sel,
	input wire logic [1:0] rise_irq,
	input wire logic [1:0] pin_out,
	input wire logic cmp0_reset_req
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [2:0] age;
	// Pipeline still holds reset-time values just after release
	always_ff @(posedge clk) begin
		if (rst) age <= 3'h0;
		else if (age != 3'h7) age <= age + 3'h1;
	end
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	sequence rise0_s; !cmp_raw[0] ##1 cmp_raw[0]; endsequence
	sequence fall1_s; cmp_raw[1] ##1 !cmp_raw[1]; endsequence
	// Enable as seen in the readback three edges on is the one the edge detector used
	a_rise_sets: assert property (rise0_s ##3 cmp0_control_reg[7] |-> ##1 cmp0_control_reg[5])
		else $error("rise flag not set");
	a_fall_sets: assert property (fall1_s ##3 cmp1_control_reg[7] |-> ##1 cmp1_control_reg[4])
		else $error("fall flag not set");
	a_flag_holds: assert property ($fell(cmp0_control_reg[5]) |->
		$past(ctrl_write[0], 2) && !$past(ctrl_wdata[5], 2))
		else $error("flag dropped without clear");
	a_out_state: assert property (age > 3'h3 |-> cmp0_control_reg[6] == $past(cmp_raw[0], 3))
		else $error("output state wrong");
	a_reset_route: assert property (cmp0_reset_req |-> cmp0_control_reg[7] && cmp0_control_reg[6])
		else $error("reset request without enabled high output");
	a_power_en: assert property (cmp_power_en[1] == cmp1_control_reg[7])
		else $error("power enable wrong");
	a_hyst_pos: assert property (cmp0_pos_hyst_sel == cmp0_control_reg[3:2])
		else $error("hysteresis select wrong");
	a_irq_mask: assert property (rise_irq[0] == (cmp0_control_reg[5] && cmp0_control_reg[7]))
		else $error("interrupt request wrong");
	a_pin_off: assert property (!cmp0_control_reg[7] |-> !pin_out[0])
		else $error("pin driven while off");
endmodule // dual_comparator_control_chk

// ---- sim/tb_dual_comparator_control.sv ----
module tb_dual_comparator_control;
	timeunit 1ns;
	timeprecision 1ns;
	`define CHK(n, e, g) begin n_compared++; if ((g) !== (e)) begin error_cnt++; \
		$display("wrong value %s exp %h got %h", n, e, g); end end
	logic clk = 1'h0;
	logic rst = 1'h1;
	logic [1:0] ctrl_write = 2'h0, cmp_raw, lvl = 2'h0, route_en = 2'h0, route_push_pull = 2'h0;
	logic [1:0] er, ef, old, cmp_power_en, rise_irq, fall_irq, pin_out, pin_oe;
	logic [7:0] ctrl_wdata = 8'h00, cmp0_control_reg, cmp1_control_reg;
	logic cmp0_reset_sel = 1'h0, cmp0_reset_req;
	cmp_ctrl_pkg::hyst_type cmp0_pos_hyst_sel, cmp0_neg_hyst_sel, cmp1_pos_hyst_sel, cmp1_neg_hyst_sel;
	int error_cnt = 0, n_compared = 0, seed = 59551, r;
	dual_comparator_control dut_u (.clk, .rst, .ctrl_write, .ctrl_wdata, .cmp_raw, .cmp0_reset_sel,
		.route_en, .route_push_pull, .cmp0_control_reg, .cmp1_control_reg, .cmp_power_en,
		.cmp0_pos_hyst_sel, .cmp0_neg_hyst_sel, .cmp1_pos_hyst_sel, .cmp1_neg_hyst_sel,
		.rise_irq, .fall_irq, .cmp0_reset_req, .pin_out, .pin_oe);
	cmp_model core_u (.clk, .pwr(cmp_power_en), .lvl, .raw(cmp_raw));
	initial forever #5 clk = ~clk;
	task cyc(int n); repeat (n) @(negedge clk); endtask
	// One write pulse, then wait until the readback has landed
	task wr(logic [1:0] w, logic [7:0] d);
		ctrl_wdata = d;
		ctrl_write = w;
		cyc(1);
		ctrl_write = 2'h0;
		cyc(2);
	endtask
	task summarize;
		$display("compared %0d mismatches %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	// Push-pull pins always drive; open-drain pins drive only a low level
	function automatic logic [1:0] oe_exp(logic [1:0] en, logic [1:0] pp, logic [1:0] l);
		return en & (pp | ~l);
	endfunction
	initial begin
		cyc(4);
		rst = 1'h0;
		cyc(1);
		`CHK("ctl regs", 16'h0000, {cmp0_control_reg, cmp1_control_reg})
		$display("test reset done");
		for (int h = 0; h < 16; h++) begin
			wr(2'h3, 8'hC0 | h[7:0]);
			`CHK("ctl0", {1'b1, h[3:0]}, {cmp0_control_reg[7], cmp0_control_reg[3:0]})
			`CHK("hyst1", h[3:0], {cmp1_pos_hyst_sel, cmp1_neg_hyst_sel})
			`CHK("hyst0", h[3:0], {cmp0_pos_hyst_sel, cmp0_neg_hyst_sel})
			`CHK("power", 2'h3, cmp_power_en)
		end
		$display("test config done");
		wr(2'h3, 8'h80);
		{er, ef, old} = {4'h0, lvl};
		// Random levels; wait beyond the sync and flag latency each step
		for (int i = 0; i < 40; i++) begin
			r = $random(seed);
			{route_en, cmp0_reset_sel, route_push_pull, lvl} = r[6:0];
			cyc(5);
			er |= lvl & ~old;
			ef |= old & ~lvl;
			old = lvl;
			`CHK("rise irq", er, rise_irq)
			`CHK("fall irq", ef, fall_irq)
			`CHK("out state", lvl, {cmp1_control_reg[6], cmp0_control_reg[6]})
			`CHK("reset req", cmp0_reset_sel & lvl[0], cmp0_reset_req)
			`CHK("pin out", lvl, pin_out)
			`CHK("pin oe", oe_exp(route_en, route_push_pull, lvl), pin_oe)
		end
		wr(2'h3, 8'hB0);
		`CHK("flags kept", {er, ef}, {rise_irq, fall_irq})
		wr(2'h3, 8'h80);
		`CHK("flags clr", 4'h0, {rise_irq, fall_irq})
		$display("test events done");
		// Edge and clear land on the same edge: the flag must survive
		lvl[0] = ~lvl[0];
		cyc(3);
		wr(2'h1, 8'h80);
		`CHK("set wins", {lvl[0], ~lvl[0]}, {rise_irq[0], fall_irq[0]})
		wr(2'h1, 8'h80);
		$display("test set wins done");
		{lvl, route_en} = 4'hF;
		wr(2'h3, 8'h00);
		lvl = 2'h0;
		cyc(5);
		`CHK("off", 6'h00, {pin_out, rise_irq, fall_irq})
		`CHK("off oe", 2'h3, pin_oe)
		$display("test disable done");
		summarize;
	end
	initial begin
		#20000;
		error_cnt++;
		summarize;
	end
endmodule // tb_dual_comparator_control
bind dual_comparator_control dual_comparator_control_chk chk_u (.clk, .rst, .ctrl_write,
	.ctrl_wdata, .cmp_raw, .cmp0_control_reg, .cmp1_control_reg, .cmp_power_en,
	.cmp0_pos_hyst_sel, .rise_irq, .pin_out, .cmp0_reset_req);
